// [inc/serial_ch0_pkg.sv]
// Purpose: constants and types shared by the channel 0 clocked serial port
// Assumes: 20 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: every register sits in the low byte, 8 bits or fewer, upper bits read as zero
package serial_ch0_pkg;

   // timing
   localparam int CLK_SYS_NS = 50;
   localparam int SCK_HALF_SLOW_NS = 400;
   localparam int SCK_HALF_FAST_NS = 200;
   localparam logic [3:0] SCK_HALF_SLOW_CYC = 4'(SCK_HALF_SLOW_NS / CLK_SYS_NS);
   localparam logic [3:0] SCK_HALF_FAST_CYC = 4'(SCK_HALF_FAST_NS / CLK_SYS_NS);

   // register byte offsets
   localparam logic [11:0] OFF_SHIFT = 12'h000;
   localparam logic [11:0] OFF_MODE = 12'h004;
   localparam logic [11:0] OFF_BUSCTL = 12'h008;
   localparam logic [11:0] OFF_SLAVE_ADDR = 12'h00C;
   localparam logic [11:0] OFF_STATUS = 12'h010;
   localparam logic [11:0] OFF_PORT0 = 12'hFF0;

   // serial_mode_reg_ch0 fields
   localparam int MODE_EN_BIT = 7;
   localparam int MODE_MATCH_BIT = 6;
   localparam int MODE_WAKE_BIT = 5;
   localparam int MODE_SEL_LSB = 3;
   localparam int MODE_LSB_FIRST_BIT = 2;
   localparam int MODE_INT_CLK_BIT = 1;
   localparam int MODE_FAST_BIT = 0;
   localparam logic [1:0] MODE_3WIRE = 2'h0;
   localparam logic [1:0] MODE_2WIRE = 2'h1;
   localparam logic [1:0] MODE_ADDR_BUS = 2'h2;

   // bus_interface_control_reg fields
   localparam int BC_REL_TRIG_BIT = 0;
   localparam int BC_CMD_TRIG_BIT = 1;
   localparam int BC_ACK_EN_BIT = 2;
   localparam int BC_BUSY_EN_BIT = 3;
   localparam int BC_PIN_B_BIT = 4;
   localparam int BC_REL_DET_BIT = 5;
   localparam int BC_CMD_DET_BIT = 6;
   localparam int BC_ACK_DET_BIT = 7;

   // status fields
   localparam int ST_IRQ_BIT = 0;
   localparam int ST_ACTIVE_BIT = 1;
   localparam int ST_PENDING_BIT = 2;

   // port 0 latch field and reset values
   localparam int PORT_CLK_LATCH_BIT = 1;
   localparam logic PORT_CLK_LATCH_RST = 1'b1;
   localparam logic [7:0] MODE_RST = 8'h00;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      XFER_IDLE = 2'b00,
      XFER_SHIFT = 2'b01,
      XFER_NINTH = 2'b10
   } xfer_state_type;

endpackage

// [hdl/clocked_serial_port_ch0.sv]
// Purpose: channel 0 clocked serial port with 3-wire, 2-wire and addressed bus modes
// Assumes: AXI4-Lite slave, one write and one read outstanding; pins sampled by clk_sys
// Notes: open-drain and push-pull pins split into in/out/oe_n, oe_n low while driving
//
// Contract
// - stop mode keeps shift register as storage
// - reset gives stop mode, data pins inputs
// - 3-wire shifts falling, captures rising, latch drives
// - stop after eight bits, set irq flag
// - mode bit 2 picks MSB or LSB
// - bit reversal applied on write only
// - 3-wire output push-pull, trigger bits set latch
// - 2-wire data pin open drain from latch
// - 2-wire shifts falling, MSB first, captures rising
// - addressed mode shifts falling, MSB first, captures rising
// - wake-up: irq only on own address match
// - write starts only if enabled and idle
// - enabling after write does not start transfer
// - wake-up keeps pull-down off while receiving
// - write during busy waits for ready high
// - idle internal clock high, pin follows latch
// - clock latch at FF0 bit 1, resets 1
// - bytes classed address, command or data
// - release rising, command falling, clock high
// - receiver holds bus low one clock
// - irq at ninth rising, gated by wake-up
module clocked_serial_port_ch0
   import serial_ch0_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // serial clock pin
   input wire logic serial_clock_pin_ch0_in,
   output logic serial_clock_pin_ch0_out,
   output logic serial_clock_pin_ch0_oe_n,
   // 3-wire data pins
   output logic serial_out_pin_ch0_out,
   output logic serial_out_pin_ch0_oe_n,
   input wire logic serial_in_pin_ch0_in,
   // open-drain data bus pins
   input wire logic data_bus_pin_a_in,
   output logic data_bus_pin_a_out,
   output logic data_bus_pin_a_oe_n,
   input wire logic data_bus_pin_b_in,
   output logic data_bus_pin_b_out,
   output logic data_bus_pin_b_oe_n,
   // transfer end flag
   output logic serial_irq_flag_ch0
);

   if (ADDR_W < 12) begin : g_addr_check
      $error("ADDR_W must be at least 12 to reach the port latch offset");
   end

   typedef struct packed {
      logic [1:0] sync_clk;
      logic [1:0] sync_si;
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic clk_prev;
      logic din_prev;
      xfer_state_type state;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic so_latch;
      logic [7:0] mode;
      logic ack_en;
      logic busy_en;
      logic pin_b;
      logic [7:0] slave_addr;
      logic port_latch;
      logic irq_flag;
      logic pending;
      logic match;
      logic rel_det;
      logic cmd_det;
      logic ack_det;
      logic ack_drive;
      logic busy_drive;
      logic [3:0] div;
      logic sck_int;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sck_out;
      logic sck_oe_n;
      logic so_out;
      logic so_oe_n;
      logic od_out;
      logic a_oe_n;
      logic b_oe_n;
   } regs_type;

   regs_type r_reg;
   regs_type r_next;

   // full-width compare so aliases above the map answer as unmapped
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
      hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(off[11:2]));
   endfunction

   function automatic logic [7:0] bit_rev(input logic [7:0] d);
      logic [7:0] o;
      o = '0;
      for (int i = 0; i < 8; i++) begin
         o[i] = d[7-i];
      end
      bit_rev = o;
   endfunction

   always_comb begin
      logic en;
      logic internal;
      logic [1:0] msel;
      logic addr_mode;
      logic od_mode;
      logic clk_level;
      logic rise;
      logic fall;
      logic din;
      logic clock_idle;
      logic wr_do;
      logic wr_shift;
      logic [7:0] wd;
      logic start;
      logic pull;
      logic [3:0] half;
      logic [7:0] rd;
      r_next = r_reg;
      en = r_reg.mode[MODE_EN_BIT];
      internal = r_reg.mode[MODE_INT_CLK_BIT];
      msel = r_reg.mode[MODE_SEL_LSB+1:MODE_SEL_LSB];
      addr_mode = (msel == MODE_ADDR_BUS);
      od_mode = en && (msel == MODE_2WIRE || addr_mode);
      start = 1'b0;
      rd = 8'h00;

      // synchronisers: logic reads only the second stage
      r_next.sync_clk = {r_reg.sync_clk[0], serial_clock_pin_ch0_in};
      r_next.sync_si = {r_reg.sync_si[0], serial_in_pin_ch0_in};
      r_next.sync_a = {r_reg.sync_a[0], data_bus_pin_a_in};
      r_next.sync_b = {r_reg.sync_b[0], data_bus_pin_b_in};

      // internal clock is observed at the pin level so a low port latch really blocks it
      clk_level = internal ? r_reg.sck_out : r_reg.sync_clk[1];
      rise = clk_level && !r_reg.clk_prev;
      fall = !clk_level && r_reg.clk_prev;
      if (msel == MODE_2WIRE || addr_mode) begin
         din = r_reg.pin_b ? r_reg.sync_b[1] : r_reg.sync_a[1];
      end else begin
         din = r_reg.sync_si[1];
      end
      r_next.clk_prev = clk_level;
      r_next.din_prev = din;
      clock_idle = internal || r_reg.sync_clk[1];

      // AXI write channels, address and data taken in either order
      if (awvalid && r_reg.awready) begin
         r_next.aw_held = 1'b1;
         r_next.aw_addr = awaddr;
      end
      if (wvalid && r_reg.wready) begin
         r_next.w_held = 1'b1;
         r_next.w_data = wdata;
         r_next.w_strb = wstrb;
      end
      if (r_reg.bvalid && bready) begin
         r_next.bvalid = 1'b0;
      end
      wr_do = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
      wd = r_reg.w_data[7:0];
      wr_shift = 1'b0;
      if (wr_do) begin
         r_next.aw_held = 1'b0;
         r_next.w_held = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         if (hit(r_reg.aw_addr, OFF_SHIFT)) begin
            wr_shift = r_reg.w_strb[0];
         end else if (hit(r_reg.aw_addr, OFF_MODE)) begin
            if (r_reg.w_strb[0]) begin
               r_next.mode = wd;
               r_next.mode[MODE_MATCH_BIT] = 1'b0;
            end
         end else if (hit(r_reg.aw_addr, OFF_BUSCTL)) begin
            if (r_reg.w_strb[0]) begin
               // triggers steer the output latch directly; legal only between transfers
               if (wd[BC_REL_TRIG_BIT]) begin
                  r_next.so_latch = 1'b1;
               end
               if (wd[BC_CMD_TRIG_BIT]) begin
                  r_next.so_latch = 1'b0;
               end
               r_next.ack_en = wd[BC_ACK_EN_BIT];
               r_next.busy_en = wd[BC_BUSY_EN_BIT];
               r_next.pin_b = wd[BC_PIN_B_BIT];
               if (!wd[BC_BUSY_EN_BIT]) begin
                  r_next.busy_drive = 1'b0;
               end
            end
         end else if (hit(r_reg.aw_addr, OFF_SLAVE_ADDR)) begin
            if (r_reg.w_strb[0]) begin
               r_next.slave_addr = wd;
            end
         end else if (hit(r_reg.aw_addr, OFF_STATUS)) begin
            if (r_reg.w_strb[0] && !wd[ST_IRQ_BIT]) begin
               r_next.irq_flag = 1'b0;
            end
         end else if (hit(r_reg.aw_addr, OFF_PORT0)) begin
            if (r_reg.w_strb[0]) begin
               r_next.port_latch = wd[PORT_CLK_LATCH_BIT];
            end
         end else begin
            r_next.bresp = RESP_SLVERR;
         end
      end
      r_next.awready = !r_next.aw_held && !r_next.bvalid;
      r_next.wready = !r_next.w_held && !r_next.bvalid;

      // AXI read channel
      if (r_reg.rvalid && rready) begin
         r_next.rvalid = 1'b0;
      end
      if (arvalid && r_reg.arready) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         if (hit(araddr, OFF_SHIFT)) begin
            rd = r_reg.shift;
         end else if (hit(araddr, OFF_MODE)) begin
            rd = r_reg.mode;
            rd[MODE_MATCH_BIT] = r_reg.match;
         end else if (hit(araddr, OFF_BUSCTL)) begin
            rd[BC_ACK_EN_BIT] = r_reg.ack_en;
            rd[BC_BUSY_EN_BIT] = r_reg.busy_en;
            rd[BC_PIN_B_BIT] = r_reg.pin_b;
            rd[BC_REL_DET_BIT] = r_reg.rel_det;
            rd[BC_CMD_DET_BIT] = r_reg.cmd_det;
            rd[BC_ACK_DET_BIT] = r_reg.ack_det;
         end else if (hit(araddr, OFF_SLAVE_ADDR)) begin
            rd = r_reg.slave_addr;
         end else if (hit(araddr, OFF_STATUS)) begin
            rd[ST_IRQ_BIT] = r_reg.irq_flag;
            rd[ST_ACTIVE_BIT] = (r_reg.state != XFER_IDLE);
            rd[ST_PENDING_BIT] = r_reg.pending;
         end else if (hit(araddr, OFF_PORT0)) begin
            rd[PORT_CLK_LATCH_BIT] = r_reg.port_latch;
         end else begin
            r_next.rresp = RESP_SLVERR;
         end
         r_next.rdata = {24'h00_0000, rd};
      end
      r_next.arready = !r_next.rvalid;

      // release and command signalling seen on the bus while the clock is high
      if (od_mode && clk_level && r_reg.clk_prev) begin
         if (din && !r_reg.din_prev) begin
            r_next.rel_det = 1'b1;
            r_next.cmd_det = 1'b0;
         end else if (!din && r_reg.din_prev) begin
            r_next.cmd_det = 1'b1;
         end
      end

      // transfer sequencer
      case (r_reg.state)
         XFER_IDLE: begin
            if (wr_shift) begin
               // reversal only on the write path, shifting always leaves bit 7 first
               if (msel != MODE_2WIRE && !addr_mode && r_reg.mode[MODE_LSB_FIRST_BIT]) begin
                  r_next.shift = bit_rev(wd);
               end else begin
                  r_next.shift = wd;
               end
               if (en) begin
                  if (addr_mode && !din) begin
                     r_next.pending = 1'b1;
                  end else if (clock_idle) begin
                     start = 1'b1;
                  end
               end
            end else if (r_reg.pending && en && din && clock_idle) begin
               start = 1'b1;
            end
         end
         XFER_SHIFT: begin
            if (fall) begin
               r_next.so_latch = r_reg.shift[7];
            end
            if (rise) begin
               r_next.shift = {r_reg.shift[6:0], din};
               r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
               if (r_reg.bit_cnt == 3'h7) begin
                  if (addr_mode) begin
                     // free the bus for the acknowledge clock
                     r_next.state = XFER_NINTH;
                     r_next.so_latch = 1'b1;
                     r_next.ack_drive = r_reg.ack_en;
                  end else begin
                     r_next.state = XFER_IDLE;
                     r_next.irq_flag = 1'b1;
                  end
               end
            end
         end
         XFER_NINTH: begin
            if (rise) begin
               r_next.state = XFER_IDLE;
               r_next.ack_drive = 1'b0;
               r_next.busy_drive = r_reg.busy_en;
               r_next.ack_det = !din;
               // an address byte follows a release; everything else is command or data
               r_next.match = r_reg.rel_det && (r_reg.shift == r_reg.slave_addr);
               if (!r_reg.mode[MODE_WAKE_BIT] || (r_reg.rel_det && r_reg.shift == r_reg.slave_addr)) begin
                  r_next.irq_flag = 1'b1;
               end
            end
         end
         default: begin
            r_next.state = XFER_IDLE;
         end
      endcase

      if (start) begin
         r_next.state = XFER_SHIFT;
         r_next.bit_cnt = 3'h0;
         r_next.pending = 1'b0;
         r_next.ack_det = 1'b0;
         r_next.busy_drive = 1'b0;
      end

      // disabling the channel stops shifting, clears the counter, keeps the flag
      if (!en) begin
         r_next.state = XFER_IDLE;
         r_next.bit_cnt = 3'h0;
         r_next.pending = 1'b0;
         r_next.ack_drive = 1'b0;
         r_next.busy_drive = 1'b0;
      end

      // internal serial clock, parked high whenever no transfer runs
      half = r_reg.mode[MODE_FAST_BIT] ? SCK_HALF_FAST_CYC : SCK_HALF_SLOW_CYC;
      if (r_reg.state != XFER_IDLE && internal) begin
         if (r_reg.div == half - 4'h1) begin
            r_next.div = 4'h0;
            r_next.sck_int = !r_reg.sck_int;
         end else begin
            r_next.div = r_reg.div + 4'h1;
         end
      end else begin
         r_next.div = 4'h0;
         r_next.sck_int = 1'b1;
      end

      // pins
      r_next.sck_oe_n = !internal;
      r_next.sck_out = r_next.sck_int && r_reg.port_latch;
      r_next.so_oe_n = !(en && msel != MODE_2WIRE && !addr_mode);
      r_next.so_out = r_reg.so_latch;
      pull = !r_reg.so_latch;
      if (addr_mode && r_reg.mode[MODE_WAKE_BIT]) begin
         pull = 1'b0;
      end
      pull = pull || r_reg.ack_drive || r_reg.busy_drive;
      r_next.od_out = 1'b0;
      r_next.a_oe_n = !(od_mode && !r_reg.pin_b && pull);
      r_next.b_oe_n = !(od_mode && r_reg.pin_b && pull);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.mode <= MODE_RST;
         r_reg.port_latch <= PORT_CLK_LATCH_RST;
         r_reg.so_latch <= 1'b1;
         r_reg.sck_int <= 1'b1;
         r_reg.sck_out <= 1'b1;
         r_reg.sck_oe_n <= 1'b1;
         r_reg.so_out <= 1'b1;
         r_reg.so_oe_n <= 1'b1;
         r_reg.a_oe_n <= 1'b1;
         r_reg.b_oe_n <= 1'b1;
         r_reg.clk_prev <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign awready = r_reg.awready;
   assign wready = r_reg.wready;
   assign bvalid = r_reg.bvalid;
   assign bresp = r_reg.bresp;
   assign arready = r_reg.arready;
   assign rvalid = r_reg.rvalid;
   assign rdata = r_reg.rdata;
   assign rresp = r_reg.rresp;
   assign serial_clock_pin_ch0_out = r_reg.sck_out;
   assign serial_clock_pin_ch0_oe_n = r_reg.sck_oe_n;
   assign serial_out_pin_ch0_out = r_reg.so_out;
   assign serial_out_pin_ch0_oe_n = r_reg.so_oe_n;
   assign data_bus_pin_a_out = r_reg.od_out;
   assign data_bus_pin_a_oe_n = r_reg.a_oe_n;
   assign data_bus_pin_b_out = r_reg.od_out;
   assign data_bus_pin_b_oe_n = r_reg.b_oe_n;
   assign serial_irq_flag_ch0 = r_reg.irq_flag;

endmodule

// [tb/serial_ch0_asserts.sv]
// Purpose: port-level checks on the channel 0 serial port
// Assumes: answer latencies as the register bus contract states them
// Notes: bound into every instance of the port
module serial_ch0_asserts
   import serial_ch0_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // pins and flag
   input wire logic serial_clock_pin_ch0_oe_n,
   input wire logic serial_out_pin_ch0_oe_n,
   input wire logic data_bus_pin_a_out,
   input wire logic data_bus_pin_a_oe_n,
   input wire logic data_bus_pin_b_oe_n,
   input wire logic serial_irq_flag_ch0
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   a_reset_pins_free:
      assert property ($rose(resetn) |-> serial_out_pin_ch0_oe_n && data_bus_pin_a_oe_n && data_bus_pin_b_oe_n
         && serial_clock_pin_ch0_oe_n && !serial_irq_flag_ch0)
         else $error("pins driven or flag set after reset");
   a_open_drain_low:
      assert property (!data_bus_pin_a_oe_n |-> !data_bus_pin_a_out)
         else $error("bus pin a driven high");
   a_one_bus_pin:
      assert property (!data_bus_pin_a_oe_n |-> data_bus_pin_b_oe_n)
         else $error("both bus pins pulled");
   a_irq_clear_write:
      assert property ($fell(serial_irq_flag_ch0) |-> bvalid || $past(bvalid))
         else $error("flag dropped without a write");
   a_write_answer:
      assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
         else $error("write not answered");
   a_read_answer:
      assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h00_0000)
         else $error("read not answered");
   a_rvalid_hold:
      assert property (rvalid && !rready |=> rvalid && $stable(rdata))
         else $error("read data not held");
   a_rd_unmapped:
      assert property (arvalid && arready && araddr == 12'h014 |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
         else $error("unmapped read not refused");

   cover property (rvalid && rresp == RESP_SLVERR);
   cover property ($rose(serial_irq_flag_ch0));
   cover property (!data_bus_pin_a_oe_n);
endmodule

bind clocked_serial_port_ch0 serial_ch0_asserts #(.ADDR_W(ADDR_W)) chk (
   .clk_sys, .resetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .araddr,
   .rvalid, .rready, .rdata, .rresp, .serial_clock_pin_ch0_oe_n, .serial_out_pin_ch0_oe_n,
   .data_bus_pin_a_out, .data_bus_pin_a_oe_n, .data_bus_pin_b_oe_n, .serial_irq_flag_ch0);

// [tb/serial_far_end.sv]
// Purpose: far-side clock master for the channel 0 serial port
// Assumes: 400 ns serial clock, clock stands high between frames
// Notes: data line shows the inverse of its last bit once released
module serial_far_end (
   // control
   input wire logic go,
   input wire logic [7:0] tx_byte,
   input wire logic [3:0] n_clk,
   input wire logic rel_first,
   output logic [7:0] rx_byte,
   output logic busy,
   // link
   input wire logic line_in,
   output logic sck,
   output logic sd,
   output logic pull_n
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      sck = 1'b1;
      sd = 1'b1;
      pull_n = 1'b1;
      busy = 1'b0;
      rx_byte = 8'h00;
   end

   always @(posedge go) begin
      busy = 1'b1;
      // odd offset keeps the link out of phase with the system clock
      #37;
      if (rel_first) begin
         pull_n = 1'b0;
         #400;
         pull_n = 1'b1;
         #400;
      end
      for (int i = 0; i < n_clk; i++) begin
         sck = 1'b0;
         sd = (i < 8) ? tx_byte[7-i] : ~sd;
         pull_n = (i < 8) ? sd : 1'b1;
         #200;
         sck = 1'b1;
         if (i < 8) rx_byte[7-i] = line_in;
         #200;
      end
      sd = ~sd;
      pull_n = 1'b1;
      busy = 1'b0;
   end
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench for the channel 0 clocked serial port
// Assumes: far end clocks every frame, registers reached by bus tasks
// Notes: random bytes from a fixed seed, with corner bytes mixed in
module testbench
   import serial_ch0_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic serial_clock_pin_ch0_out, serial_clock_pin_ch0_oe_n, serial_out_pin_ch0_out, serial_out_pin_ch0_oe_n;
   logic data_bus_pin_a_out, data_bus_pin_a_oe_n, data_bus_pin_b_out, data_bus_pin_b_oe_n, serial_irq_flag_ch0;
   logic far_go = 1'b0, far_rel = 1'b0, use_bus = 1'b0;
   logic [7:0] far_tx = 8'h00;
   logic [3:0] far_n = 4'h8;
   logic [7:0] far_rx, x, y, v;
   logic far_busy, far_sck, far_sd, far_pull_n, sck_w, bus_a, bus_b, far_in;
   int error_cnt = 0;
   int n_checks = 0;

   always #25 clk_sys = ~clk_sys;

   // wired levels: bus pins pulled up, clock line shared
   assign sck_w = (serial_clock_pin_ch0_oe_n | serial_clock_pin_ch0_out) & far_sck;
   assign bus_a = (data_bus_pin_a_oe_n | data_bus_pin_a_out) & far_pull_n;
   assign bus_b = data_bus_pin_b_oe_n | data_bus_pin_b_out;
   assign far_in = use_bus ? bus_a : serial_out_pin_ch0_out;

   clocked_serial_port_ch0 dut (
      .clk_sys, .resetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
      .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
      .rready, .rdata, .rresp, .serial_clock_pin_ch0_in(sck_w), .serial_clock_pin_ch0_out,
      .serial_clock_pin_ch0_oe_n, .serial_out_pin_ch0_out, .serial_out_pin_ch0_oe_n,
      .serial_in_pin_ch0_in(far_sd), .data_bus_pin_a_in(bus_a), .data_bus_pin_a_out, .data_bus_pin_a_oe_n,
      .data_bus_pin_b_in(bus_b), .data_bus_pin_b_out, .data_bus_pin_b_oe_n, .serial_irq_flag_ch0);

   serial_far_end far (.go(far_go), .tx_byte(far_tx), .n_clk(far_n), .rel_first(far_rel), .rx_byte(far_rx),
      .busy(far_busy), .line_in(far_in), .sck(far_sck), .sd(far_sd), .pull_n(far_pull_n));

   function automatic logic [7:0] rev8(input logic [7:0] d);
      for (int i = 0; i < 8; i++) rev8[i] = d[7-i];
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      do begin
         @(posedge clk_sys);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
      end while (!bvalid);
      chk(32'(bresp), 32'(er));
   endtask

   // rready stays high, so the answer is taken at the first edge rvalid is seen
   task automatic axi_rd(input logic [11:0] a, output logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      arvalid <= 1'b1;
      araddr <= a;
      do begin
         @(posedge clk_sys);
         if (arready && arvalid) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata[7:0];
      chk(32'(rresp), 32'(er));
   endtask

   task automatic frame(input logic [7:0] tx, input logic [3:0] n, input logic bus_release_signal);
      far_tx <= tx;
      far_n <= n;
      far_rel <= bus_release_signal;
      far_go <= 1'b1;
      @(posedge clk_sys);
      far_go <= 1'b0;
      wait (!far_busy);
      repeat (10) @(posedge clk_sys);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      error_cnt++;
      $display("ERROR at %0t ns: watchdog expired", $time);
      report_and_stop;
   end

   initial begin
      void'($urandom(74633));
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk({serial_out_pin_ch0_oe_n, data_bus_pin_a_oe_n, data_bus_pin_b_oe_n, serial_irq_flag_ch0}, 4'hE);
      axi_rd(OFF_MODE, v);
      chk(v, MODE_RST);
      axi_rd(OFF_PORT0, v);
      chk(v[PORT_CLK_LATCH_BIT], PORT_CLK_LATCH_RST);
      $display("test reset done");
      x = 8'($urandom);
      axi_wr(OFF_SHIFT, x);
      axi_wr(OFF_MODE, 8'h80);
      frame(8'($urandom), 4'h8, 1'b0);
      axi_rd(OFF_SHIFT, v);
      chk(v, x);
      chk(serial_irq_flag_ch0, 1'b0);
      $display("test stop mode done");
      for (int k = 0; k < 6; k++) begin
         x = (k == 0) ? 8'h80 : 8'($urandom);
         y = (k == 1) ? 8'h01 : 8'($urandom);
         axi_wr(OFF_STATUS, 8'h00);
         axi_wr(OFF_MODE, (k > 2) ? 8'h84 : 8'h80);
         chk(serial_irq_flag_ch0, 1'b0);
         axi_wr(OFF_SHIFT, x);
         frame(y, 4'h8, 1'b0);
         chk(far_rx, (k > 2) ? rev8(x) : x);
         axi_rd(OFF_SHIFT, v);
         chk(v, y);
         chk(serial_irq_flag_ch0, 1'b1);
      end
      $display("test three wire done");
      for (int k = 0; k < 4; k++) begin
         if (k == 2) axi_wr(OFF_MODE, 8'h88);
         axi_wr(OFF_BUSCTL, k[0] ? 8'h01 : 8'h02);
         repeat (3) @(posedge clk_sys);
         chk(k[1] ? bus_a : serial_out_pin_ch0_out, k[0]);
      end
      use_bus <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         x = (k == 2) ? 8'hFF : 8'($urandom);
         y = 8'($urandom);
         axi_wr(OFF_SHIFT, x);
         frame(y, 4'h8, 1'b0);
         chk(far_rx, x & y);
         axi_rd(OFF_SHIFT, v);
         chk(v, x & y);
      end
      $display("test two wire done");
      axi_wr(OFF_MODE, 8'h90);
      axi_wr(OFF_BUSCTL, 8'h05);
      axi_wr(OFF_STATUS, 8'h00);
      x = 8'($urandom);
      axi_wr(OFF_SHIFT, x);
      frame(8'hFF, 4'h9, 1'b0);
      chk(far_rx, x);
      chk(serial_irq_flag_ch0, 1'b1);
      axi_rd(OFF_BUSCTL, v);
      chk(v[BC_ACK_DET_BIT], 1'b1);
      axi_wr(OFF_SLAVE_ADDR, x);
      axi_wr(OFF_MODE, 8'hB0);
      for (int k = 0; k < 2; k++) begin
         axi_wr(OFF_STATUS, 8'h00);
         axi_wr(OFF_SHIFT, 8'h00);
         y = k[0] ? x : ~x;
         frame(y, 4'h9, 1'b1);
         chk(far_rx, y);
         chk(serial_irq_flag_ch0, k[0]);
      end
      $display("test addressed bus done");
      axi_wr(OFF_MODE, 8'h82);
      for (int k = 0; k < 2; k++) begin
         axi_wr(OFF_PORT0, k[0] ? 8'h02 : 8'h00);
         repeat (2) @(posedge clk_sys);
         chk({serial_clock_pin_ch0_oe_n, serial_clock_pin_ch0_out}, {1'b0, k[0]});
      end
      axi_wr(12'h014, 8'h5A, RESP_SLVERR);
      axi_rd(12'h014, v, RESP_SLVERR);
      chk(v, 8'h00);
      $display("test port latch and unmapped done");
      report_and_stop;
   end
endmodule
